// ### lcdc_pkg.sv
package lcdc_pkg;
  localparam int RAM_PAGES = 9;
  localparam int RAM_COLS = 132;
  localparam int RAM_DEPTH = RAM_PAGES * RAM_COLS;
  localparam int RAM_AW = 11;
  localparam int BUF_WIDTH = 9;
  localparam int BUF_DEPTH = 2;
  localparam int PIN_W = 15;
  localparam int PIN_DC = 8;
  localparam int PIN_WR = 9;
  localparam int PIN_RD = 10;
  localparam int PIN_CS1N = 11;
  localparam int PIN_CS2 = 12;
  localparam int PIN_STYLE = 13;
  localparam int PIN_PAR = 14;
  localparam int SER_CLK = 6;
  localparam int SER_DAT = 7;
  localparam logic [14:0] PIN_IDLE = 15'h4e00;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic [7:0] MASK_B0 = 8'hfe;
  localparam logic [7:0] MASK_NIB = 8'hf0;
  localparam logic [7:0] MASK_B3 = 8'hf8;
  localparam logic [7:0] MASK_B6 = 8'hc0;
  localparam logic [7:0] CMD_ONOFF = 8'hae;
  localparam logic [7:0] CMD_LINE = 8'h40;
  localparam logic [7:0] CMD_PAGE = 8'hb0;
  localparam logic [7:0] CMD_COLHI = 8'h10;
  localparam logic [7:0] CMD_COLLO = 8'h00;
  localparam logic [7:0] CMD_ADC = 8'ha0;
  localparam logic [7:0] CMD_INV = 8'ha6;
  localparam logic [7:0] CMD_ALLON = 8'ha4;
  localparam logic [7:0] CMD_BIAS = 8'ha2;
  localparam logic [7:0] CMD_RMW = 8'he0;
  localparam logic [7:0] CMD_END = 8'hee;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  localparam logic [7:0] CMD_COM = 8'hc0;
  localparam logic [7:0] CMD_POWER = 8'h28;
  localparam logic [7:0] CMD_RATIO = 8'h20;
  localparam logic [7:0] CMD_VOLUME = 8'h81;
  localparam logic [7:0] CMD_IND = 8'hac;
  localparam logic [7:0] CMD_TEST = 8'hf0;
  localparam logic [3:0] STATUS_LOW = 4'h0;
  typedef enum logic [1:0] {EXPECT_CMD, EXPECT_VOLUME, EXPECT_FLASH} expect_t;
  typedef struct packed {
    logic display_on;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] col;
    logic seg_reverse;
    logic invert;
    logic all_on;
    logic bias;
    logic rmw;
    logic [7:0] rmw_col;
    logic com_reverse;
    logic [2:0] power;
    logic [2:0] ratio;
    logic [5:0] volume;
    logic indicator;
    logic [1:0] flash;
    logic test_mode;
  } settings_t;
  localparam settings_t SETTINGS_DEFAULT = '0;
endpackage : lcdc_pkg

// ### lcd_byte_buf.sv
`timescale 1ns/10ps
module lcd_byte_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= (AW+1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= (AW+1)'(count_reg - 1'b1);
      end
    end
  end

  // payload needs no reset, valid comes from count
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule : lcd_byte_buf

// ### lcd_controller_host_command_decoder.sv
`timescale 1ns/10ps
module lcd_controller_host_command_decoder (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic select_low_active_n_i,
  input wire logic select_high_active_i,
  input wire logic data_command_select_i,
  input wire logic wr_rw_i,
  input wire logic rd_e_i,
  input wire logic bus_style_select_i,
  input wire logic parallel_select_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic upd_valid_o,
  input wire logic upd_ready_i,
  output logic [3:0] upd_page_o,
  output logic [7:0] upd_col_o,
  output logic [7:0] upd_data_o,
  output logic display_on_o,
  output logic [5:0] start_line_o,
  output logic [3:0] page_o,
  output logic [7:0] column_o,
  output logic seg_reverse_o,
  output logic invert_o,
  output logic all_on_o,
  output logic bias_sel_o,
  output logic com_reverse_o,
  output logic [2:0] power_ctrl_o,
  output logic [2:0] resistor_ratio_o,
  output logic [5:0] volume_o,
  output logic indicator_on_o,
  output logic [1:0] flash_mode_o,
  output logic rmw_mode_o,
  output logic test_mode_o,
  output logic power_save_o,
  output logic overrun_o
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [lcdc_pkg::PIN_W-1:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  logic sel, par, pin_dc, par_act, par_read, act_reg, acc_read_reg, acc_dc_reg;
  logic [7:0] acc_data_reg;
  logic wr_fire, rd_start, rd_end;
  logic scl, si, scl_reg, scl_rise, ser_fire;
  logic [2:0] ser_cnt_reg;
  logic [6:0] ser_shift_reg;
  logic in_valid, in_ready, buf_valid, exec_ready, exec_fire, ex_dc, ram_wr, in_range, col_inc, cmd_fire;
  logic [lcdc_pkg::BUF_WIDTH-1:0] in_data, buf_data;
  logic [7:0] ex_byte, ram_rd, data_out_reg;
  logic [lcdc_pkg::RAM_AW-1:0] ram_idx;
  logic [7:0] ram_mem [lcdc_pkg::RAM_DEPTH];
  lcdc_pkg::settings_t cfg_reg, cfg_next;
  lcdc_pkg::expect_t expect_reg, expect_next;
  logic data_oe_n_reg, upd_valid_reg, power_save_reg, overrun_reg;
  logic [3:0] upd_page_reg;
  logic [7:0] upd_col_reg, upd_data_reg;

  function automatic logic hit(input logic [7:0] b, input logic [7:0] code, input logic [7:0] mask);
    return (b & mask) == code;
  endfunction : hit

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // every pin is asynchronous to clock_i; a bit moves only when stages two and three agree
  assign pin_raw = {parallel_select_i, bus_style_select_i, select_high_active_i, select_low_active_n_i,
                    rd_e_i, wr_rw_i, data_command_select_i, data_i};
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= lcdc_pkg::PIN_IDLE;
      pin_s2_reg <= lcdc_pkg::PIN_IDLE;
      pin_s3_reg <= lcdc_pkg::PIN_IDLE;
      pin_reg <= lcdc_pkg::PIN_IDLE;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  assign sel = !pin_reg[lcdc_pkg::PIN_CS1N] && pin_reg[lcdc_pkg::PIN_CS2];
  assign par = pin_reg[lcdc_pkg::PIN_PAR];
  assign pin_dc = pin_reg[lcdc_pkg::PIN_DC];
  // style high: enable/read-write pair; style low: separate active-low strobes
  assign par_act = sel && par && (pin_reg[lcdc_pkg::PIN_STYLE] ? pin_reg[lcdc_pkg::PIN_RD]
                   : (!pin_reg[lcdc_pkg::PIN_WR] || !pin_reg[lcdc_pkg::PIN_RD]));
  assign par_read = pin_reg[lcdc_pkg::PIN_STYLE] ? pin_reg[lcdc_pkg::PIN_WR] : !pin_reg[lcdc_pkg::PIN_RD];
  assign rd_start = par_act && !act_reg && par_read;
  assign wr_fire = act_reg && !par_act && !acc_read_reg;
  assign rd_end = act_reg && !par_act && acc_read_reg;

  // data keeps tracking the bus until the strobe releases, so the last value wins
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
      acc_read_reg <= 1'b0;
      acc_dc_reg <= 1'b0;
      acc_data_reg <= 8'h00;
    end else begin
      act_reg <= par_act;
      if (par_act) begin
        acc_read_reg <= par_read;
        acc_dc_reg <= pin_dc;
        acc_data_reg <= pin_reg[7:0];
      end
    end
  end

  assign scl = pin_reg[lcdc_pkg::SER_CLK];
  assign si = pin_reg[lcdc_pkg::SER_DAT];
  assign scl_rise = sel && !par && scl && !scl_reg;
  assign ser_fire = scl_rise && (ser_cnt_reg == lcdc_pkg::SER_LAST);

  // deselecting mid-byte drops the partial byte
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_reg <= 1'b0;
      ser_cnt_reg <= 3'h0;
      ser_shift_reg <= 7'h00;
    end else begin
      scl_reg <= scl;
      if (!sel || par) begin
        ser_cnt_reg <= 3'h0;
      end else if (scl_rise) begin
        ser_shift_reg <= {ser_shift_reg[5:0], si};
        ser_cnt_reg <= 3'(ser_cnt_reg + 3'h1);
      end
    end
  end

  assign in_valid = wr_fire || ser_fire;
  assign in_data = wr_fire ? {acc_dc_reg, acc_data_reg} : {pin_dc, ser_shift_reg, si};

  lcd_byte_buf #(
    .WIDTH(lcdc_pkg::BUF_WIDTH),
    .DEPTH(lcdc_pkg::BUF_DEPTH)
  ) u_byte_buf (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i(in_data),
    .out_valid_o(buf_valid),
    .out_ready_i(exec_ready),
    .out_data_o(buf_data)
  );

  // the host cannot be stalled; a byte arriving to a full buffer is dropped and flagged
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (in_valid && !in_ready) begin
      overrun_reg <= 1'b1;
    end
  end

  assign exec_ready = !upd_valid_reg || upd_ready_i;
  assign exec_fire = buf_valid && exec_ready;
  assign ex_dc = buf_data[8];
  assign ex_byte = buf_data[7:0];
  assign cmd_fire = exec_fire && !ex_dc && (expect_reg == lcdc_pkg::EXPECT_CMD);
  assign ram_wr = exec_fire && ex_dc;
  assign in_range = (int'(cfg_reg.page) < lcdc_pkg::RAM_PAGES) && (int'(cfg_reg.col) < lcdc_pkg::RAM_COLS);
  assign ram_idx = lcdc_pkg::RAM_AW'(int'(cfg_reg.page) * lcdc_pkg::RAM_COLS + int'(cfg_reg.col));
  assign ram_rd = in_range ? ram_mem[ram_idx] : 8'h00;
  assign col_inc = ram_wr || (rd_end && acc_dc_reg && !cfg_reg.rmw);

  always_ff @(posedge clock_i) begin
    if (ram_wr && in_range) begin
      ram_mem[ram_idx] <= ex_byte;
    end
  end

  always_comb begin
    cfg_next = cfg_reg;
    expect_next = expect_reg;
    if (col_inc) begin
      cfg_next.col = 8'(cfg_reg.col + 8'h01);
    end
    if (exec_fire && !ex_dc) begin
      case (expect_reg)
        lcdc_pkg::EXPECT_VOLUME: begin
          cfg_next.volume = ex_byte[5:0];
          expect_next = lcdc_pkg::EXPECT_CMD;
        end
        lcdc_pkg::EXPECT_FLASH: begin
          cfg_next.flash = ex_byte[1:0];
          expect_next = lcdc_pkg::EXPECT_CMD;
        end
        default: begin
          if (hit(ex_byte, lcdc_pkg::CMD_ONOFF, lcdc_pkg::MASK_B0)) begin
            cfg_next.display_on = ex_byte[0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_LINE, lcdc_pkg::MASK_B6)) begin
            cfg_next.start_line = ex_byte[5:0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_PAGE, lcdc_pkg::MASK_NIB)) begin
            cfg_next.page = ex_byte[3:0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_COLHI, lcdc_pkg::MASK_NIB)) begin
            cfg_next.col[7:4] = ex_byte[3:0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_COLLO, lcdc_pkg::MASK_NIB)) begin
            cfg_next.col[3:0] = ex_byte[3:0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_ADC, lcdc_pkg::MASK_B0)) begin
            cfg_next.seg_reverse = ex_byte[0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_INV, lcdc_pkg::MASK_B0)) begin
            cfg_next.invert = ex_byte[0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_ALLON, lcdc_pkg::MASK_B0)) begin
            cfg_next.all_on = ex_byte[0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_BIAS, lcdc_pkg::MASK_B0)) begin
            cfg_next.bias = ex_byte[0];
          end else if (ex_byte == lcdc_pkg::CMD_RMW) begin
            cfg_next.rmw = 1'b1;
            cfg_next.rmw_col = cfg_reg.col;
          end else if (ex_byte == lcdc_pkg::CMD_END) begin
            // leaving the mode puts the column back where it started
            cfg_next.rmw = 1'b0;
            cfg_next.col = cfg_reg.rmw ? cfg_reg.rmw_col : cfg_next.col;
          end else if (ex_byte == lcdc_pkg::CMD_RESET) begin
            cfg_next = lcdc_pkg::SETTINGS_DEFAULT;
          end else if (hit(ex_byte, lcdc_pkg::CMD_COM, lcdc_pkg::MASK_NIB)) begin
            cfg_next.com_reverse = ex_byte[3];
          end else if (hit(ex_byte, lcdc_pkg::CMD_POWER, lcdc_pkg::MASK_B3)) begin
            cfg_next.power = ex_byte[2:0];
          end else if (hit(ex_byte, lcdc_pkg::CMD_RATIO, lcdc_pkg::MASK_B3)) begin
            cfg_next.ratio = ex_byte[2:0];
          end else if (ex_byte == lcdc_pkg::CMD_VOLUME) begin
            expect_next = lcdc_pkg::EXPECT_VOLUME;
          end else if (hit(ex_byte, lcdc_pkg::CMD_IND, lcdc_pkg::MASK_B0)) begin
            cfg_next.indicator = ex_byte[0];
            expect_next = lcdc_pkg::EXPECT_FLASH;
          end else if (ex_byte == lcdc_pkg::CMD_TEST) begin
            cfg_next.test_mode = 1'b0;
          end else if (hit(ex_byte, lcdc_pkg::CMD_TEST, lcdc_pkg::MASK_NIB)) begin
            cfg_next.test_mode = 1'b1;
          end
          // nop and unknown codes fall through untouched
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= lcdc_pkg::SETTINGS_DEFAULT;
      expect_reg <= lcdc_pkg::EXPECT_CMD;
      power_save_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      expect_reg <= expect_next;
      power_save_reg <= !cfg_next.display_on && cfg_next.all_on;
    end
  end

  // read data only valid some cycles after the strobe, set by the pin synchroniser
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_n_reg <= 1'b1;
      data_out_reg <= 8'h00;
    end else begin
      data_oe_n_reg <= !(par_act && par_read);
      if (rd_start) begin
        data_out_reg <= pin_dc ? ram_rd : {buf_valid, cfg_reg.seg_reverse, !cfg_reg.display_on, 1'b0,
                                           lcdc_pkg::STATUS_LOW};
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      upd_valid_reg <= 1'b0;
      upd_page_reg <= 4'h0;
      upd_col_reg <= 8'h00;
      upd_data_reg <= 8'h00;
    end else if (ram_wr && in_range) begin
      upd_valid_reg <= 1'b1;
      upd_page_reg <= cfg_reg.page;
      upd_col_reg <= cfg_reg.col;
      upd_data_reg <= ex_byte;
    end else if (upd_ready_i) begin
      upd_valid_reg <= 1'b0;
    end
  end

  assign data_o = data_out_reg;
  assign data_oe_n_o = data_oe_n_reg;
  assign upd_valid_o = upd_valid_reg;
  assign upd_page_o = upd_page_reg;
  assign upd_col_o = upd_col_reg;
  assign upd_data_o = upd_data_reg;
  assign display_on_o = cfg_reg.display_on;
  assign start_line_o = cfg_reg.start_line;
  assign page_o = cfg_reg.page;
  assign column_o = cfg_reg.col;
  assign seg_reverse_o = cfg_reg.seg_reverse;
  assign invert_o = cfg_reg.invert;
  assign all_on_o = cfg_reg.all_on;
  assign bias_sel_o = cfg_reg.bias;
  assign com_reverse_o = cfg_reg.com_reverse;
  assign power_ctrl_o = cfg_reg.power;
  assign resistor_ratio_o = cfg_reg.ratio;
  assign volume_o = cfg_reg.volume;
  assign indicator_on_o = cfg_reg.indicator;
  assign flash_mode_o = cfg_reg.flash;
  assign rmw_mode_o = cfg_reg.rmw;
  assign test_mode_o = cfg_reg.test_mode;
  assign power_save_o = power_save_reg;
  assign overrun_o = overrun_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_bus_idle_float: assert property (!sel |=> data_oe_n_o) else $error("bus driven while deselected");
  a_cmd_no_ram: assert property (exec_fire && !ex_dc |=> $stable(upd_data_o)) else $error("command hit ram");
  a_write_on_release: assert property ($fell(par_act) && !acc_read_reg |-> in_valid
    && in_data[7:0] == acc_data_reg) else $error("write byte not taken");
  a_access_overlap: assert property (wr_fire |-> $past(sel, 1) && par) else $error("write without overlap");
  a_disp_onoff: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_ONOFF, lcdc_pkg::MASK_B0)
    |=> display_on_o == $past(ex_byte[0])) else $error("on/off");
  a_start_line: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_LINE, lcdc_pkg::MASK_B6)
    |=> start_line_o == $past(ex_byte[5:0])) else $error("start line");
  a_page_load: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_PAGE, lcdc_pkg::MASK_NIB)
    |=> page_o == $past(ex_byte[3:0])) else $error("page");
  a_col_high: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_COLHI, lcdc_pkg::MASK_NIB) && !col_inc
    |=> column_o == {$past(ex_byte[3:0]), $past(column_o[3:0])}) else $error("column high");
  a_status_read: assert property (rd_start && !pin_dc |=> data_o[3:0] == 4'h0
    && data_o[7] == $past(buf_valid) && !data_oe_n_o) else $error("status");
  a_ram_write: assert property (ram_wr && in_range |=> upd_valid_o && upd_data_o == $past(ex_byte)
    && upd_col_o == $past(column_o)) else $error("ram write");
  a_ram_read: assert property (rd_start && pin_dc |=> data_o == $past(ram_rd)) else $error("ram read");
  a_seg_map: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_ADC, lcdc_pkg::MASK_B0)
    |=> seg_reverse_o == $past(ex_byte[0])) else $error("segment map");
  a_invert_sel: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_INV, lcdc_pkg::MASK_B0)
    |=> invert_o == $past(ex_byte[0])) else $error("invert");
  a_all_on: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_ALLON, lcdc_pkg::MASK_B0)
    |=> all_on_o == $past(ex_byte[0])) else $error("all on");
  a_bias_sel: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_BIAS, lcdc_pkg::MASK_B0)
    |=> bias_sel_o == $past(ex_byte[0])) else $error("bias");
  a_rmw_read_hold: assert property (rd_end && acc_dc_reg && rmw_mode_o && !exec_fire
    |=> $stable(column_o)) else $error("read moved column");
  a_com_dir: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_COM, lcdc_pkg::MASK_NIB)
    |=> com_reverse_o == $past(ex_byte[3])) else $error("scan direction");
  a_power_ctrl: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_POWER, lcdc_pkg::MASK_B3)
    |=> power_ctrl_o == $past(ex_byte[2:0])) else $error("power control");
  a_ratio_sel: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_RATIO, lcdc_pkg::MASK_B3)
    |=> resistor_ratio_o == $past(ex_byte[2:0])) else $error("resistor ratio");
  a_volume_pair: assert property (exec_fire && !ex_dc && expect_reg == lcdc_pkg::EXPECT_VOLUME
    |=> volume_o == $past(ex_byte[5:0]) && expect_reg == lcdc_pkg::EXPECT_CMD) else $error("volume");
  a_indicator_pair: assert property (cmd_fire && hit(ex_byte, lcdc_pkg::CMD_IND, lcdc_pkg::MASK_B0)
    |=> indicator_on_o == $past(ex_byte[0]) && expect_reg == lcdc_pkg::EXPECT_FLASH) else $error("indicator");
  a_power_save: assert property (power_save_o == (!display_on_o && all_on_o)) else $error("power save");
  a_test_exit: assert property (cmd_fire && ex_byte == lcdc_pkg::CMD_TEST |=> !test_mode_o) else $error("test");
  a_soft_reset: assert property (cmd_fire && ex_byte == lcdc_pkg::CMD_RESET
    |=> cfg_reg == lcdc_pkg::SETTINGS_DEFAULT) else $error("soft reset");
  a_serial_wonly: assert property (!par |=> data_oe_n_o) else $error("serial drove bus");

  c_serial_byte: cover property (ser_fire ##[1:10] exec_fire);
  c_ram_read: cover property (rd_start && pin_dc ##[1:20] rd_end);
  c_buf_full: cover property (!in_ready ##[1:50] in_ready);
  logic a_v_done;
  assign a_v_done = exec_fire && expect_reg == lcdc_pkg::EXPECT_VOLUME;
  c_volume_seq: cover property (cmd_fire && ex_byte == lcdc_pkg::CMD_VOLUME ##[1:100] a_v_done);
endmodule : lcd_controller_host_command_decoder

// ### lcd_host_model.sv
`timescale 1ns/10ps
module lcd_host_model (
  input wire logic clock_i,
  output logic sel_n_o,
  output logic dc_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic [7:0] bus_o
);
  initial begin
    {sel_n_o, dc_o, wr_n_o, rd_n_o, bus_o} = 12'hb00;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : gap
  // one separate-strobe cycle; callers also send test-range bytes, such as the f0 in t_save
  task automatic xfer(input logic sel, input logic dc, input logic rd, input logic [7:0] b);
    gap(1);
    sel_n_o = ~sel;
    dc_o = dc;
    // a released bus shows the inverse, not a stale copy
    bus_o = rd ? ~bus_o : b;
    gap(6);
    rd_n_o = ~rd;
    wr_n_o = rd;
    gap(8);
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    gap(6);
    sel_n_o = 1'b1;
    bus_o = ~bus_o;
  endtask : xfer
  // serial byte: clock on bus bit 6, data on bit 7, msb first, clock idles low
  task automatic ser(input logic dc, input logic [7:0] b);
    gap(1);
    bus_o = 8'h00;
    sel_n_o = 1'b0;
    dc_o = dc;
    for (int i = 7; i >= 0; i--) begin
      gap(5);
      bus_o = {b[i], 1'b0, 6'h00};
      gap(5);
      bus_o[6] = 1'b1;
    end
    gap(5);
    sel_n_o = 1'b1;
    bus_o = 8'h00;
  endtask : ser
  // enable style: read/write level on the write pin, enable active high on the read pin
  task automatic xfer_e(input logic rd, input logic dc, input logic [7:0] b);
    gap(1);
    rd_n_o = 1'b0;
    wr_n_o = rd;
    sel_n_o = 1'b0;
    dc_o = dc;
    bus_o = rd ? ~bus_o : b;
    gap(6);
    rd_n_o = 1'b1;
    gap(8);
    rd_n_o = 1'b0;
    gap(6);
    sel_n_o = 1'b1;
    bus_o = ~bus_o;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
  endtask : xfer_e
endmodule : lcd_host_model

// ### lcd_controller_host_command_decoder_tb.sv
`timescale 1ns/10ps
module lcd_controller_host_command_decoder_tb;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic upd_ready_i = 1'b1;
  logic cs2 = 1'b1;
  logic style = 1'b0;
  logic par_sel = 1'b1;
  logic sel_n, dc, wr_n, rd_n;
  logic [7:0] bus;
  wire [7:0] rdat, udat, ucol;
  wire [3:0] upage;
  wire [38:0] st;
  wire uv, ps, ovr, rmw, oe_n, tm;
  int oe_low = 0;
  int miscompares = 0;
  int samples_checked = 0;
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  // counted on the falling edge, where the registered enable has settled
  always @(negedge clock_i) begin
    if (oe_n === 1'b0) begin
      oe_low++;
    end
  end
  lcd_host_model i_lcd_host_model (.clock_i(clock_i), .sel_n_o(sel_n), .dc_o(dc), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .bus_o(bus));
  lcd_controller_host_command_decoder i_lcd_controller_host_command_decoder (.clock_i(clock_i),
    .nrst_i(nrst_i), .select_low_active_n_i(sel_n), .select_high_active_i(cs2), .data_command_select_i(dc),
    .wr_rw_i(wr_n), .rd_e_i(rd_n), .bus_style_select_i(style), .parallel_select_i(par_sel), .data_i(bus),
    .data_o(rdat), .data_oe_n_o(oe_n), .upd_valid_o(uv), .upd_ready_i(upd_ready_i), .upd_page_o(upage),
    .upd_col_o(ucol), .upd_data_o(udat), .display_on_o(st[38]), .start_line_o(st[37:32]),
    .page_o(st[31:28]), .column_o(st[27:20]), .seg_reverse_o(st[19]), .invert_o(st[18]), .all_on_o(st[17]),
    .bias_sel_o(st[16]), .com_reverse_o(st[15]), .power_ctrl_o(st[14:12]), .resistor_ratio_o(st[11:9]),
    .volume_o(st[8:3]), .indicator_on_o(st[2]), .flash_mode_o(st[1:0]), .rmw_mode_o(rmw),
    .test_mode_o(tm), .power_save_o(ps), .overrun_o(ovr));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic d, input logic [7:0] b);
    i_lcd_host_model.xfer(1'b1, d, 1'b0, b);
    repeat (10) @(posedge clock_i);
  endtask : w
  task automatic r(input logic d);
    i_lcd_host_model.xfer(1'b1, d, 1'b1, 8'h00);
    repeat (10) @(posedge clock_i);
  endtask : r
  task automatic cmds(input logic [7:0] b[$]);
    foreach (b[i]) w(1'b0, b[i]);
  endtask : cmds
  task automatic t_cmds;
    cmds({8'haf, 8'h6a, 8'hb3, 8'h15, 8'h07, 8'ha1, 8'ha7, 8'ha3, 8'hc8, 8'h2d, 8'h25, 8'h81, 8'hff, 8'had, 8'h02});
    chk(st, {1'b1, 6'h2a, 4'h3, 8'h57, 5'h1b, 3'h5, 3'h5, 6'h3f, 1'b1, 2'h2});
    $display("settings test done");
  endtask : t_cmds
  task automatic es(input logic rd, input logic d, input logic [7:0] b);
    i_lcd_host_model.xfer_e(rd, d, b);
    repeat (10) @(posedge clock_i);
  endtask : es
  task automatic t_status;
    int n;
    #2 cs2 = 1'b0;
    i_lcd_host_model.xfer(1'b1, 1'b0, 1'b0, 8'hae);
    cs2 = 1'b1;
    i_lcd_host_model.xfer(1'b0, 1'b0, 1'b0, 8'hae);
    n = oe_low;
    r(1'b0);
    chk({st[38], rdat}, {1'b1, 8'h40});
    chk(oe_low - n, 8);
    $display("status test done");
  endtask : t_status
  task automatic t_ram;
    w(1'b1, 8'h5a);
    chk(st[27:20], 8'h58);
    cmds({8'h15, 8'h07});
    r(1'b1);
    chk({rdat, st[27:20]}, {8'h5a, 8'h58});
    // reads must hold the column in this mode
    cmds({8'he0, 8'h15, 8'h07});
    r(1'b1);
    chk({rmw, rdat, st[27:20]}, {1'b1, 8'h5a, 8'h57});
    w(1'b1, 8'h3c);
    chk(st[27:20], 8'h58);
    cmds({8'hee});
    chk(rmw, 1'b0);
    $display("ram test done");
  endtask : t_ram
  task automatic t_save;
    cmds({8'hae, 8'ha5});
    chk({ps, st[38], st[17]}, 3'h5);
    cmds({8'he2, 8'he3, 8'hf0});
    chk({ps, rmw, tm, st}, 48'h0);
    $display("power save test done");
  endtask : t_save
  task automatic t_stall;
    @(posedge clock_i);
    #2 upd_ready_i = 1'b0;
    for (int i = 0; i < 5; i++) w(1'b1, 8'ha0 + 8'(i));
    chk({uv, ovr, upage, ucol, udat}, {2'h3, 4'h0, 8'h00, 8'ha0});
    @(posedge clock_i);
    #2 upd_ready_i = 1'b1;
    repeat (10) @(posedge clock_i);
    chk({uv, ovr}, 2'h1);
    $display("stall test done");
  endtask : t_stall
  task automatic t_ser;
    #2 par_sel = 1'b0;
    i_lcd_host_model.ser(1'b0, 8'hb5);
    repeat (10) @(posedge clock_i);
    i_lcd_host_model.ser(1'b1, 8'h77);
    repeat (10) @(posedge clock_i);
    chk({upage, ucol, udat, st[31:20], oe_n}, {4'h5, 8'h03, 8'h77, 4'h5, 8'h04, 1'b1});
    #2 par_sel = 1'b1;
    $display("serial test done");
  endtask : t_ser
  task automatic t_style;
    int n;
    @(posedge clock_i);
    #2 style = 1'b1;
    es(1'b0, 1'b1, 8'h99);
    es(1'b0, 1'b0, 8'h04);
    n = oe_low;
    es(1'b1, 1'b1, 8'h00);
    chk({rdat, udat, ucol, st[27:20]}, {8'h99, 8'h99, 8'h04, 8'h05});
    chk(oe_low - n, 8);
    $display("enable style test done");
  endtask : t_style
  task automatic close_out;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (12) @(posedge clock_i);
    #2 nrst_i = 1'b1;
    repeat (5) @(posedge clock_i);
    t_cmds;
    t_status;
    t_ram;
    t_save;
    t_stall;
    t_ser;
    t_style;
    close_out;
  end
  // about 60 us of traffic expected
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
endmodule : lcd_controller_host_command_decoder_tb
